// *** logic/ppp_prog_port.sv ***
`timescale 1ns/100ps
module ppp_prog_port #(
   parameter int FLASH_WORDS = ppp_pkg::FLASH_WORDS_DEF,
   parameter int FLASH_PAGE_WORDS = ppp_pkg::FLASH_PAGE_WORDS_DEF,
   parameter int EE_BYTES = ppp_pkg::EE_BYTES_DEF,
   parameter int EE_PAGE_BYTES = ppp_pkg::EE_PAGE_BYTES_DEF
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // high voltage present on the reset pin
   input wire logic HV_RESET_DET,
   // programmer strobes and selects
   input wire ppp_pkg::ppp_ctl_t PRG_CTL,
   // eight-bit data bus, split
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   // fuse
   input wire logic EEPROM_PRESERVE_FUSE,
   // status
   output logic READY_BUSY_OUT,
   output logic PROG_MODE,
   output logic [7:0] LOCK_BITS
);
   import ppp_pkg::*;

   localparam int FAW = $clog2(FLASH_WORDS);
   localparam int PAW = $clog2(FLASH_PAGE_WORDS);
   localparam int EAW = $clog2(EE_BYTES);
   localparam int EPAW = $clog2(EE_PAGE_BYTES);

   ppp_ctl_t ctl_prev_q;
   logic hv_prev_q;
   ppp_mode_t mode_q;
   logic [3:0] guard_cnt_q;
   ppp_op_t op_q;
   logic [FAW-1:0] idx_q;
   logic [FAW-PAW-1:0] pg_q;
   logic [EAW-EPAW-1:0] epg_q;
   logic [7:0] cmd_q;
   logic [7:0] addr_lo_q;
   logic [7:0] addr_hi_q;
   logic [7:0] data_lo_q;
   logic [7:0] data_hi_q;
   logic [7:0] lock_q;
   logic [7:0] rd_q;
   logic oe_q;
   logic [15:0] fbuf_q [FLASH_PAGE_WORDS];
   logic [7:0] ebuf_q [EE_PAGE_BYTES];
   logic [15:0] flash_mem [FLASH_WORDS];
   logic [7:0] ee_mem [EE_BYTES];

   logic [3:0] prog_en;
   logic hv_rise;
   logic xtal_rise;
   logic page_latch_pin_rise;
   logic wr_fall;
   logic active;
   logic accept;
   logic [1:0] act;
   logic load_cmd;
   logic [15:0] addr;
   logic start_erase;
   logic start_flash;
   logic start_ee;

   assign prog_en = {PRG_CTL.page_latch_pin, PRG_CTL.action_select_hi,
                     PRG_CTL.action_select_lo, PRG_CTL.byte_select_first};
   assign hv_rise = HV_RESET_DET & ~hv_prev_q;
   assign xtal_rise = PRG_CTL.crystal_input_pin & ~ctl_prev_q.crystal_input_pin;
   assign page_latch_pin_rise = PRG_CTL.page_latch_pin & ~ctl_prev_q.page_latch_pin;
   assign wr_fall = ctl_prev_q.write_n & ~PRG_CTL.write_n;
   assign active = (mode_q == MD_ACTIVE);
   // nothing is taken while an operation runs, so it always completes
   assign accept = active & (op_q == OP_IDLE);
   assign act = {PRG_CTL.action_select_hi, PRG_CTL.action_select_lo};
   assign load_cmd = accept & xtal_rise & (act == ACT_CMD);
   assign addr = {addr_hi_q, addr_lo_q};
   assign start_erase = accept & wr_fall & (cmd_q == CMD_ERASE);
   assign start_flash = accept & wr_fall & ~PRG_CTL.byte_select_first
                        & (cmd_q == CMD_WR_FLASH);
   assign start_ee = accept & wr_fall & ~PRG_CTL.byte_select_first
                     & (cmd_q == CMD_WR_EE);

   ////////////////////////////////////////////////////////////////////////////
   // edge history
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctl_prev_q <= '0;
         hv_prev_q <= 1'b0;
      end else begin
         ctl_prev_q <= PRG_CTL;
         hv_prev_q <= HV_RESET_DET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode entry; once failed, stays out until high voltage is removed
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q <= MD_OFF;
         guard_cnt_q <= 4'h0;
      end else if (!HV_RESET_DET) begin
         mode_q <= MD_OFF;
         guard_cnt_q <= 4'h0;
      end else begin
         case (mode_q)
            MD_OFF: begin
               if (hv_rise) begin
                  mode_q <= (prog_en == ENTRY_PATTERN) ? MD_SETTLE : MD_FAIL;
                  guard_cnt_q <= 4'h0;
               end
            end
            MD_SETTLE: begin
               if (prog_en != ENTRY_PATTERN) begin
                  mode_q <= MD_FAIL;
               end else if (guard_cnt_q == ENTRY_GUARD_CYC - 4'h1) begin
                  mode_q <= MD_ACTIVE;
               end else begin
                  guard_cnt_q <= guard_cnt_q + 4'h1;
               end
            end
            MD_ACTIVE: mode_q <= MD_ACTIVE;
            MD_FAIL: mode_q <= MD_FAIL;
            default: mode_q <= MD_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // byte loads, bus sampled only on the crystal rising edge
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cmd_q <= CMD_NOP;
         addr_lo_q <= 8'h00;
         addr_hi_q <= 8'h00;
         data_lo_q <= 8'h00;
         data_hi_q <= 8'h00;
      end else if (accept && xtal_rise) begin
         case (act)
            ACT_CMD: cmd_q <= DATA_IN;
            ACT_ADDR: begin
               if (PRG_CTL.byte_select_first) begin
                  addr_hi_q <= DATA_IN;
               end else begin
                  addr_lo_q <= DATA_IN;
               end
            end
            ACT_DATA: begin
               if (PRG_CTL.byte_select_first) begin
                  data_hi_q <= DATA_IN;
               end else begin
                  data_lo_q <= DATA_IN;
               end
            end
            default: cmd_q <= cmd_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page buffers; erased words leave flash cells untouched on programming
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < FLASH_PAGE_WORDS; i++) fbuf_q[i] <= ERASED_WORD;
         for (int j = 0; j < EE_PAGE_BYTES; j++) ebuf_q[j] <= ERASED_BYTE;
      end else if (load_cmd && DATA_IN == CMD_NOP) begin
         for (int i = 0; i < FLASH_PAGE_WORDS; i++) fbuf_q[i] <= ERASED_WORD;
         for (int j = 0; j < EE_PAGE_BYTES; j++) ebuf_q[j] <= ERASED_BYTE;
      end else if (op_q == OP_PROG_FLASH) begin
         fbuf_q[idx_q[PAW-1:0]] <= ERASED_WORD;
      end else if (op_q == OP_PROG_EE) begin
         ebuf_q[idx_q[EPAW-1:0]] <= ERASED_BYTE;
      end else if (accept && page_latch_pin_rise && PRG_CTL.byte_select_first) begin
         if (cmd_q == CMD_WR_FLASH) begin
            fbuf_q[addr_lo_q[PAW-1:0]] <= {data_hi_q, data_lo_q};
         end else if (cmd_q == CMD_WR_EE) begin
            ebuf_q[addr_lo_q[EPAW-1:0]] <= data_lo_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation sequencer
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         op_q <= OP_IDLE;
         idx_q <= '0;
         pg_q <= '0;
         epg_q <= '0;
      end else begin
         case (op_q)
            OP_IDLE: begin
               idx_q <= '0;
               if (start_erase) begin
                  op_q <= OP_ERASE_FLASH;
               end else if (start_flash) begin
                  op_q <= OP_PROG_FLASH;
                  // address bits above the in-page word offset pick the page
                  pg_q <= addr[FAW-1:PAW];
               end else if (start_ee) begin
                  op_q <= OP_PROG_EE;
                  epg_q <= addr[EAW-1:EPAW];
               end
            end
            OP_ERASE_FLASH: begin
               if (idx_q == FAW'(FLASH_WORDS - 1)) begin
                  idx_q <= '0;
                  op_q <= EEPROM_PRESERVE_FUSE ? OP_ERASE_LOCK : OP_ERASE_EE;
               end else begin
                  idx_q <= idx_q + 1'b1;
               end
            end
            OP_ERASE_EE: begin
               if (idx_q == FAW'(EE_BYTES - 1)) begin
                  op_q <= OP_ERASE_LOCK;
               end else begin
                  idx_q <= idx_q + 1'b1;
               end
            end
            OP_ERASE_LOCK: op_q <= OP_IDLE;
            OP_PROG_FLASH: begin
               if (idx_q == FAW'(FLASH_PAGE_WORDS - 1)) begin
                  op_q <= OP_IDLE;
               end else begin
                  idx_q <= idx_q + 1'b1;
               end
            end
            OP_PROG_EE: begin
               if (idx_q == FAW'(EE_PAGE_BYTES - 1)) begin
                  op_q <= OP_IDLE;
               end else begin
                  idx_q <= idx_q + 1'b1;
               end
            end
            default: op_q <= OP_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arrays; nonvolatile, so no reset
   always_ff @(posedge SYS_CLK) begin
      if (op_q == OP_ERASE_FLASH) begin
         flash_mem[idx_q] <= ERASED_WORD;
      end else if (op_q == OP_PROG_FLASH) begin
         flash_mem[{pg_q, idx_q[PAW-1:0]}] <=
            flash_mem[{pg_q, idx_q[PAW-1:0]}] & fbuf_q[idx_q[PAW-1:0]];
      end
      if (op_q == OP_ERASE_EE) begin
         ee_mem[idx_q[EAW-1:0]] <= ERASED_BYTE;
      end else if (op_q == OP_PROG_EE) begin
         ee_mem[{epg_q, idx_q[EPAW-1:0]}] <=
            ee_mem[{epg_q, idx_q[EPAW-1:0]}] & ebuf_q[idx_q[EPAW-1:0]];
      end
   end

   // lock bits clear only after flash, and eeprom unless preserved, are done; fuses are not touched here
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lock_q <= LOCK_RST_VAL;
      end else if (op_q == OP_ERASE_LOCK) begin
         lock_q <= LOCK_CLEAR_VAL;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path; one cycle of latency from select change to bus
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_q <= 8'h00;
         oe_q <= 1'b0;
      end else begin
         rd_q <= PRG_CTL.byte_select_first ? flash_mem[addr[FAW-1:0]][15:8]
                                           : flash_mem[addr[FAW-1:0]][7:0];
         oe_q <= active & ~PRG_CTL.out_enable_n & (cmd_q == CMD_RD_FLASH);
      end
   end

   assign DATA_OUT = rd_q;
   assign DATA_OE = oe_q;
   assign READY_BUSY_OUT = (op_q == OP_IDLE);
   assign PROG_MODE = active;
   assign LOCK_BITS = lock_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   // run length of busy; saturates so a long erase cannot wrap it
   logic [7:0] busy_run_q;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         busy_run_q <= 8'h00;
      end else if (READY_BUSY_OUT) begin
         busy_run_q <= 8'h00;
      end else if (busy_run_q != 8'hff) begin
         busy_run_q <= busy_run_q + 8'h01;
      end
   end

   sequence s_clean_entry;
      hv_rise && prog_en == ENTRY_PATTERN ##1 (HV_RESET_DET && prog_en == ENTRY_PATTERN)[*4];
   endsequence
   sequence s_erase_req;
      accept && wr_fall && cmd_q == CMD_ERASE;
   endsequence
   sequence s_flash_req;
      accept && wr_fall && !PRG_CTL.byte_select_first && cmd_q == CMD_WR_FLASH;
   endsequence
   // ready comes back after exactly one page of busy cycles
   sequence s_flash_done;
      READY_BUSY_OUT && busy_run_q == 8'(FLASH_PAGE_WORDS);
   endsequence

   AST_ENTRY_OK: assert property (s_clean_entry |=> active)
      else $error("clean entry did not reach programming mode");
   AST_ENTRY_REFUSE: assert property (mode_q == MD_SETTLE && prog_en != ENTRY_PATTERN
      |=> (!active)[*4])
      else $error("mode entered despite pin activity");
   AST_ERASE_START: assert property (s_erase_req |=> !READY_BUSY_OUT
      && op_q == OP_ERASE_FLASH)
      else $error("chip erase did not start busy");
   AST_FLASH_PROG: assert property (s_flash_req |=> !READY_BUSY_OUT ##[1:70] s_flash_done)
      else $error("flash page program busy length wrong");
   AST_CMD_HOLD: assert property (!load_cmd |=> $stable(cmd_q))
      else $error("command changed without a load");
   AST_BUSY_IGNORE: assert property (!READY_BUSY_OUT && xtal_rise
      |=> $stable(cmd_q) && $stable(addr))
      else $error("load taken while busy");
   AST_LOCK_ORDER: assert property ($rose(op_q == OP_ERASE_LOCK)
      |-> $past(op_q) == OP_ERASE_EE || $past(op_q) == OP_ERASE_FLASH)
      else $error("lock bits cleared before arrays erased");
   AST_EE_PRESERVE: assert property (op_q == OP_ERASE_FLASH && idx_q == FAW'(FLASH_WORDS - 1)
      && EEPROM_PRESERVE_FUSE |=> op_q == OP_ERASE_LOCK)
      else $error("eeprom erased with preserve fuse set");
   AST_NOP_CLEAR: assert property (load_cmd && DATA_IN == CMD_NOP
      |=> fbuf_q[0] == ERASED_WORD && ebuf_q[0] == ERASED_BYTE)
      else $error("no-op did not clear the page buffers");
   AST_BUS_DRIVE: assert property (DATA_OE |-> $past(!PRG_CTL.out_enable_n && active
      && cmd_q == CMD_RD_FLASH))
      else $error("data bus driven without output enable");

endmodule

// *** logic/ppp_pkg.sv ***
package ppp_pkg;

   // pin group sampled by the port; all fields active high unless _n
   typedef struct packed {
      logic crystal_input_pin;
      logic action_select_hi;
      logic action_select_lo;
      logic byte_select_first;
      logic page_latch_pin;
      logic write_n;
      logic out_enable_n;
   } ppp_ctl_t;

   typedef enum logic [1:0] {MD_OFF, MD_SETTLE, MD_ACTIVE, MD_FAIL} ppp_mode_t;

   typedef enum logic [2:0] {
      OP_IDLE, OP_ERASE_FLASH, OP_ERASE_EE, OP_ERASE_LOCK, OP_PROG_FLASH, OP_PROG_EE
   } ppp_op_t;

   // command bytes
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EE = 8'h11;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;

   // action-select coding {hi, lo}
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;

   // mode-entry pin pattern {page latch, action hi, action lo, byte select}
   localparam logic [3:0] ENTRY_PATTERN = 4'h0;

   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int ENTRY_GUARD_NS = 100;
   localparam int ENTRY_GUARD_CYC_I = (ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] ENTRY_GUARD_CYC = 4'(ENTRY_GUARD_CYC_I);

   // memory geometry
   localparam int FLASH_WORDS_DEF = 8192;
   localparam int FLASH_PAGE_WORDS_DEF = 64;
   localparam int EE_BYTES_DEF = 512;
   localparam int EE_PAGE_BYTES_DEF = 4;

   // erased / reset values
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] LOCK_RST_VAL = 8'hfc;
   localparam logic [7:0] LOCK_CLEAR_VAL = 8'hff;

endpackage

// *** verification/ppp_prog_model.sv ***
`timescale 1ns/100ps
module ppp_prog_model (
   // clock and status from the port
   input wire logic clk,
   input wire logic ready,
   // programmer pins
   output logic hv,
   output ppp_pkg::ppp_ctl_t ctl,
   output logic [7:0] bus
);
   import ppp_pkg::*;

   localparam ppp_ctl_t IDLE_PINS = '{write_n: 1'b1, out_enable_n: 1'b1, default: 1'b0};

   initial begin
      hv = 1'b0;
      ctl = IDLE_PINS;
      bus = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // spoil: 0 clean, 1 pin moves inside the guard, 2 pin wrong at the rise,
   // 3 no crystal pulses, long settle after high voltage instead
   task automatic enter(input int spoil);
      hv = 1'b0;
      ctl = IDLE_PINS;
      repeat (spoil == 3 ? 0 : 6) begin
         ctl.crystal_input_pin = 1'b1;
         step(1);
         ctl.crystal_input_pin = 1'b0;
         step(1);
      end
      ctl.byte_select_first = (spoil == 2);
      step(4);
      hv = 1'b1;
      step(2);
      ctl.action_select_lo = (spoil == 1);
      step(1);
      ctl = IDLE_PINS;
      step(spoil == 3 ? 4000 : 4);
   endtask

   task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] val);
      {ctl.action_select_hi, ctl.action_select_lo} = act;
      ctl.byte_select_first = bs;
      bus = val;
      ctl.crystal_input_pin = 1'b1;
      step(1);
      ctl.crystal_input_pin = 1'b0;
      // released bus shows the inverse, so a stale byte never reads back
      bus = ~val;
      step(1);
   endtask

   task automatic latch();
      ctl.byte_select_first = 1'b1;
      ctl.page_latch_pin = 1'b1;
      step(1);
      ctl.page_latch_pin = 1'b0;
      step(1);
   endtask

   task automatic write_pulse(input logic bs);
      ctl.byte_select_first = bs;
      ctl.write_n = 1'b0;
      step(1);
      ctl.write_n = 1'b1;
   endtask

   // edges until ready is seen, at least one, so back-to-back strobes stay apart;
   // bounded so a stuck port cannot hang the run
   task automatic wait_ready(output int busy);
      busy = 0;
      do begin
         step(1);
         busy++;
      end while (ready !== 1'b1 && busy < 20000);
   endtask

   task automatic oe(input logic en, input logic bs);
      ctl.out_enable_n = ~en;
      ctl.byte_select_first = bs;
      step(3);
   endtask
endmodule

// *** verification/ppp_prog_port_tb.sv ***
`timescale 1ns/100ps
module ppp_prog_port_tb;
   import ppp_pkg::*;

   localparam int FW = 256;
   localparam int EB = 16;

   logic SYS_CLK;
   logic RST_N;
   logic fuse;
   logic hv;
   ppp_ctl_t ctl;
   logic [7:0] bus;
   logic [7:0] din;
   logic [7:0] dout;
   logic [7:0] lock;
   logic doe;
   logic rdy;
   logic mode;
   int failures = 0;
   int checked = 0;
   int n;
   logic [7:0] wa [3] = '{8'h40, 8'h7f, 8'h41};
   logic [15:0] wd [3] = '{16'h1234, 16'ha55a, 16'h00ff};

   always #12.5 SYS_CLK = ~SYS_CLK;

   // the shared wire: port drives while its enable is high
   assign din = doe ? dout : bus;

   ppp_prog_port #(.FLASH_WORDS(FW), .EE_BYTES(EB)) ppp_prog_port_inst (
      .SYS_CLK(SYS_CLK), .RST_N(RST_N), .HV_RESET_DET(hv), .PRG_CTL(ctl), .DATA_IN(din),
      .DATA_OUT(dout), .DATA_OE(doe), .EEPROM_PRESERVE_FUSE(fuse), .READY_BUSY_OUT(rdy),
      .PROG_MODE(mode), .LOCK_BITS(lock));

   ppp_prog_model ppp_prog_model_inst (
      .clk(SYS_CLK), .ready(rdy), .hv(hv), .ctl(ctl), .bus(bus));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic ld(input logic [1:0] act, input logic bs, input logic [7:0] val);
      ppp_prog_model_inst.load(act, bs, val);
   endtask

   task automatic read_word(input logic [7:0] lo, input logic [15:0] exp);
      ld(ACT_ADDR, 1'b0, lo);
      ppp_prog_model_inst.oe(1'b1, 1'b0);
      check("bus enable on read", doe, 1'b1);
      check("flash low byte", dout, exp[7:0]);
      ppp_prog_model_inst.oe(1'b1, 1'b1);
      check("flash high byte", dout, exp[15:8]);
      ppp_prog_model_inst.oe(1'b0, 1'b0);
      check("bus released", doe, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("ready after reset", rdy, 1'b1);
      check("mode after reset", mode, 1'b0);
      check("bus after reset", doe, 1'b0);
      check("lock after reset", lock, LOCK_RST_VAL);
   endtask

   task automatic t_entry();
      ppp_prog_model_inst.enter(2);
      check("entry with pin set", mode, 1'b0);
      ppp_prog_model_inst.enter(1);
      check("entry with pin moving", mode, 1'b0);
      ppp_prog_model_inst.enter(3);
      check("entry without crystal pulses", mode, 1'b1);
      ppp_prog_model_inst.enter(0);
      check("clean entry", mode, 1'b1);
   endtask

   // busy length shows whether eeprom was part of the erase
   task automatic t_erase(input logic keep, input int exp);
      fuse = keep;
      ld(ACT_CMD, 1'b0, CMD_ERASE);
      ppp_prog_model_inst.write_pulse(1'b0);
      ppp_prog_model_inst.wait_ready(n);
      check("erase busy length", 16'(n), 16'(exp));
      check("lock after erase", lock, LOCK_CLEAR_VAL);
   endtask

   task automatic t_flash();
      ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
      ld(ACT_ADDR, 1'b1, 8'h00);
      read_word(8'h40, ERASED_WORD);
      ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
      for (int i = 0; i < 3; i++) begin
         ld(ACT_ADDR, 1'b0, wa[i]);
         ld(ACT_DATA, 1'b0, wd[i][7:0]);
         ld(ACT_DATA, 1'b1, wd[i][15:8]);
         ppp_prog_model_inst.latch();
      end
      ppp_prog_model_inst.write_pulse(1'b0);
      // loads and a second strobe while busy must change nothing
      ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
      ppp_prog_model_inst.write_pulse(1'b0);
      ppp_prog_model_inst.wait_ready(n);
      check("page busy length", 16'(n), 16'd61);
      ppp_prog_model_inst.oe(1'b1, 1'b0);
      check("command load while busy", doe, 1'b0);
      ppp_prog_model_inst.oe(1'b0, 1'b0);
      ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
      for (int i = 0; i < 3; i++) begin
         read_word(wa[i], wd[i]);
      end
      read_word(8'h42, ERASED_WORD);
   endtask

   task automatic t_nop();
      ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
      ld(ACT_ADDR, 1'b0, 8'h80);
      ld(ACT_DATA, 1'b0, 8'h34);
      ld(ACT_DATA, 1'b1, 8'h12);
      ppp_prog_model_inst.latch();
      ld(ACT_CMD, 1'b0, CMD_NOP);
      ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
      ppp_prog_model_inst.write_pulse(1'b0);
      ppp_prog_model_inst.wait_ready(n);
      check("nop page busy length", 16'(n), 16'd64);
      ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
      read_word(8'h80, ERASED_WORD);
   endtask

   task automatic t_eeprom();
      ld(ACT_CMD, 1'b0, CMD_WR_EE);
      ld(ACT_ADDR, 1'b1, 8'h00);
      for (int i = 0; i < 4; i++) begin
         ld(ACT_ADDR, 1'b0, 8'(i));
         ld(ACT_DATA, 1'b0, 8'(8'h30 + i));
         ppp_prog_model_inst.latch();
      end
      ppp_prog_model_inst.write_pulse(1'b1);
      check("no start with high byte select", rdy, 1'b1);
      ppp_prog_model_inst.wait_ready(n);
      // ready on the first look
      check("strobe with high byte select", 16'(n), 16'd1);
      ppp_prog_model_inst.write_pulse(1'b0);
      ppp_prog_model_inst.wait_ready(n);
      check("eeprom busy length", 16'(n), 16'd4);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      SYS_CLK = 1'b0;
      RST_N = 1'b0;
      fuse = 1'b0;
      repeat (16) @(posedge SYS_CLK);
      #1;
      RST_N = 1'b1;
      t_reset();
      t_entry();
      t_erase(1'b1, FW + 1);
      t_erase(1'b0, FW + EB + 1);
      t_flash();
      t_nop();
      t_eeprom();
      print_verdict();
   end

   // about three times the expected run
   initial begin
      #400000;
      failures++;
      print_verdict();
   end
endmodule
